// File: logic/pin_select_defines.vh
// Purpose: constants for the remappable pin select multiplexer
// Assumes: one register word per selector field, data in low bits
// Notes: addresses are word indexes on the plain register port
`ifndef PIN_SELECT_DEFINES_VH
`define PIN_SELECT_DEFINES_VH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define IN_SEL_W 7
`define OUT_SEL_W 6
`define NUM_PERIPH_IN 24
`define NUM_RP_PINS 15
`define NUM_RPI_PINS 20
`define ADDR_W 6
`define DATA_W 16

// ----------------------------------------------------------------
// register map: inputs at 0..23, outputs at 32..46
// ----------------------------------------------------------------
`define IN_SEL_BASE 6'h00
`define OUT_SEL_BASE 6'h20
`define SEL_RESET_IN 7'h00
`define SEL_RESET_OUT 6'h00

// ----------------------------------------------------------------
// input source codes
// ----------------------------------------------------------------
`define IN_GROUND 7'h00
`define IN_CMP1 7'h01
`define IN_CMP2 7'h02
`define IN_CMP3 7'h03
`define IN_CMP4 7'h04
`define IN_TRIG30 7'h06
`define IN_TRIG31 7'h07
`define IN_FINDEX 7'h08
`define IN_FHOME 7'h09

// ----------------------------------------------------------------
// output function codes
// ----------------------------------------------------------------
`define OUT_DEFAULT 6'h00
`define OUT_UART1_TX 6'h01
`define OUT_UART2_TX 6'h03
`define OUT_SPI_DO 6'h08
`define OUT_SPI_CK 6'h09
`define OUT_SPI_SS 6'h0a
`define OUT_CAN_TX 6'h0e
`define OUT_OC1 6'h10
`define OUT_OC2 6'h11
`define OUT_OC3 6'h12
`define OUT_OC4 6'h13
`define OUT_CMP1 6'h18
`define OUT_CMP2 6'h19
`define OUT_CMP3 6'h1a
`define OUT_SYNC 6'h2d
`define OUT_QCMP 6'h2f
`define OUT_REFCLK 6'h31
`define OUT_CMP4 6'h32

`endif

// File: logic/remappable_pin_select_mux.v
// Purpose: routes peripheral inputs from pins or internal sources and peripheral outputs onto pins
// Assumes: pin inputs are asynchronous and are synchronised here; peripheral signals share sys_clk
// Notes: outputs are registered, so routing follows a selector write by one extra cycle
//        full pins 118 and 120 have no pad on this part, so their input codes read low
`timescale 1ns/10ps
`include "pin_select_defines.vh"

module remappable_pin_select_mux (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // register port
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`DATA_W-1:0] reg_rdata,
  // physical pins, full remappable then input only, bit order as listed below
  input wire [`NUM_RP_PINS-1:0] remappable_io_pin_in,
  input wire [`NUM_RPI_PINS-1:0] remappable_input_only_pin,
  input wire [`NUM_RP_PINS-1:0] port_data_out,
  input wire [`NUM_RP_PINS-1:0] port_data_oe,
  input wire [`NUM_RP_PINS-1:0] analog_enable,
  output reg [`NUM_RP_PINS-1:0] remappable_io_pin_out,
  output reg [`NUM_RP_PINS-1:0] remappable_io_pin_oe,
  // internal virtual sources
  input wire comparator_out_one,
  input wire comparator_out_two,
  input wire comparator_out_three,
  input wire comparator_out_four,
  input wire trigger_gen_out_30,
  input wire trigger_gen_out_31,
  input wire filtered_encoder_index,
  input wire filtered_encoder_home,
  // peripheral outputs to be placed on pins
  input wire uart_one_transmit,
  input wire uart_two_transmit,
  input wire spi_b_data_out,
  input wire spi_b_clock_out,
  input wire spi_b_select_out,
  input wire can_transmit,
  input wire compare_out_one,
  input wire compare_out_two,
  input wire compare_out_three,
  input wire compare_out_four,
  input wire pwm_sync_out,
  input wire encoder_count_compare_out,
  input wire reference_clock_out,
  // peripheral inputs, index order: ext int 1, ext int 2, timer2 clock, capture 1..4,
  // compare fault a, pwm fault 1, 2, encoder a, b, index, home, uart rx 1, 2,
  // spi data in, spi clock in, spi select in, can rx, pwm sync in, deadtime 1..3
  output reg [`NUM_PERIPH_IN-1:0] periph_in
);

  // ----------------------------------------------------------------
  // pin numbering
  // ----------------------------------------------------------------
  // full pins: 20,35..43,54..57,97 (15); 118/120 come after them in rp_num and have no bit
  // input-only pins: 24,25,27,28,32,33,34,44,45,46,47,51,52,53,58,94,95,96,119,121
  function [6:0] rp_num;
    input integer i;
    begin
      case (i)
        0: rp_num = 7'h14;
        1: rp_num = 7'h23;
        2: rp_num = 7'h24;
        3: rp_num = 7'h25;
        4: rp_num = 7'h26;
        5: rp_num = 7'h27;
        6: rp_num = 7'h28;
        7: rp_num = 7'h29;
        8: rp_num = 7'h2a;
        9: rp_num = 7'h2b;
        10: rp_num = 7'h36;
        11: rp_num = 7'h37;
        12: rp_num = 7'h38;
        13: rp_num = 7'h39;
        14: rp_num = 7'h61;
        15: rp_num = 7'h76;
        default: rp_num = 7'h78;
      endcase
    end
  endfunction

  function [6:0] rpi_num;
    input integer i;
    begin
      case (i)
        0: rpi_num = 7'h18;
        1: rpi_num = 7'h19;
        2: rpi_num = 7'h1b;
        3: rpi_num = 7'h1c;
        4: rpi_num = 7'h20;
        5: rpi_num = 7'h21;
        6: rpi_num = 7'h22;
        7: rpi_num = 7'h2c;
        8: rpi_num = 7'h2d;
        9: rpi_num = 7'h2e;
        10: rpi_num = 7'h2f;
        11: rpi_num = 7'h33;
        12: rpi_num = 7'h34;
        13: rpi_num = 7'h35;
        14: rpi_num = 7'h3a;
        15: rpi_num = 7'h5e;
        16: rpi_num = 7'h5f;
        17: rpi_num = 7'h60;
        18: rpi_num = 7'h77;
        default: rpi_num = 7'h79;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pads are asynchronous; two stages keep metastability away from the mux
  reg [`NUM_RP_PINS-1:0] io_meta_reg;
  reg [`NUM_RP_PINS-1:0] io_sync_reg;
  reg [`NUM_RPI_PINS-1:0] ionly_meta_reg;
  reg [`NUM_RPI_PINS-1:0] ionly_sync_reg;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_meta_reg <= {`NUM_RP_PINS{1'b0}};
      io_sync_reg <= {`NUM_RP_PINS{1'b0}};
      ionly_meta_reg <= {`NUM_RPI_PINS{1'b0}};
      ionly_sync_reg <= {`NUM_RPI_PINS{1'b0}};
    end else begin
      io_meta_reg <= remappable_io_pin_in;
      io_sync_reg <= io_meta_reg;
      ionly_meta_reg <= remappable_input_only_pin;
      ionly_sync_reg <= ionly_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // selector registers
  // ----------------------------------------------------------------
  reg [`IN_SEL_W-1:0] input_map_selector_reg [0:`NUM_PERIPH_IN-1];
  reg [`OUT_SEL_W-1:0] output_map_selector_reg [0:`NUM_RP_PINS-1];
  reg [`DATA_W-1:0] reg_rdata_next;
  integer wr_idx;
  integer rd_idx;
  integer in_idx;
  integer out_idx;
  integer dec_idx;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // one compare per field, shared by write and read so both agree on the map
  reg [`NUM_PERIPH_IN-1:0] in_hit;
  reg [`NUM_RP_PINS-1:0] out_hit;

  always @* begin
    in_hit = {`NUM_PERIPH_IN{1'b0}};
    out_hit = {`NUM_RP_PINS{1'b0}};
    for (dec_idx = 0; dec_idx < `NUM_PERIPH_IN; dec_idx = dec_idx + 1)
      in_hit[dec_idx] = (reg_addr == `IN_SEL_BASE + dec_idx[5:0]);
    for (dec_idx = 0; dec_idx < `NUM_RP_PINS; dec_idx = dec_idx + 1)
      out_hit[dec_idx] = (reg_addr == `OUT_SEL_BASE + dec_idx[5:0]);
  end

  // each write touches one field only, so other routes never glitch
  // upper data bits are dropped here and read back as zero
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (wr_idx = 0; wr_idx < `NUM_PERIPH_IN; wr_idx = wr_idx + 1)
        input_map_selector_reg[wr_idx] <= `SEL_RESET_IN;
      for (wr_idx = 0; wr_idx < `NUM_RP_PINS; wr_idx = wr_idx + 1)
        output_map_selector_reg[wr_idx] <= `SEL_RESET_OUT;
    end else if (reg_wr) begin
      for (wr_idx = 0; wr_idx < `NUM_PERIPH_IN; wr_idx = wr_idx + 1)
        if (in_hit[wr_idx])
          input_map_selector_reg[wr_idx] <= reg_wdata[`IN_SEL_W-1:0];
      for (wr_idx = 0; wr_idx < `NUM_RP_PINS; wr_idx = wr_idx + 1)
        if (out_hit[wr_idx])
          output_map_selector_reg[wr_idx] <= reg_wdata[`OUT_SEL_W-1:0];
    end
  end

  // unmapped addresses read as zero
  always @* begin
    reg_rdata_next = {`DATA_W{1'b0}};
    for (rd_idx = 0; rd_idx < `NUM_PERIPH_IN; rd_idx = rd_idx + 1)
      if (in_hit[rd_idx])
        reg_rdata_next = {9'h000, input_map_selector_reg[rd_idx]};
    for (rd_idx = 0; rd_idx < `NUM_RP_PINS; rd_idx = rd_idx + 1)
      if (out_hit[rd_idx])
        reg_rdata_next = {10'h000, output_map_selector_reg[rd_idx]};
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= {`DATA_W{1'b0}};
    else if (reg_rd)
      reg_rdata <= reg_rdata_next;
    else
      reg_rdata <= {`DATA_W{1'b0}};
  end

  // ----------------------------------------------------------------
  // input routing
  // ----------------------------------------------------------------
  // analog pins have their digital input buffer off, so they read low
  function route_in;
    input [6:0] sel;
    input [`NUM_RP_PINS-1:0] io_v;
    input [`NUM_RPI_PINS-1:0] ionly_v;
    input [8:0] virt;
    integer j;
    begin
      route_in = 1'b0;
      case (sel)
        `IN_GROUND: route_in = 1'b0;
        `IN_CMP1: route_in = virt[0];
        `IN_CMP2: route_in = virt[1];
        `IN_CMP3: route_in = virt[2];
        `IN_CMP4: route_in = virt[3];
        `IN_TRIG30: route_in = virt[4];
        `IN_TRIG31: route_in = virt[5];
        `IN_FINDEX: route_in = virt[6];
        `IN_FHOME: route_in = virt[7];
        // these codes have nothing behind them and stay low instead of entering the pin search
        7'h05: route_in = 1'b0;
        7'h76, 7'h78: route_in = 1'b0; // full pins without a pad here
        7'h7a, 7'h7b, 7'h7c, 7'h7d, 7'h7e, 7'h7f: route_in = 1'b0; // above the top pin
        default: begin
          for (j = 0; j < `NUM_RP_PINS; j = j + 1)
            if (sel == rp_num(j))
              route_in = io_v[j];
          for (j = 0; j < `NUM_RPI_PINS; j = j + 1)
            if (sel == rpi_num(j))
              route_in = ionly_v[j];
        end
      endcase
    end
  endfunction

  wire [8:0] virt_src;
  wire [`NUM_RP_PINS-1:0] io_digital;
  reg [`NUM_PERIPH_IN-1:0] periph_in_next;

  assign virt_src = {1'b0, filtered_encoder_home, filtered_encoder_index, trigger_gen_out_31,
                     trigger_gen_out_30, comparator_out_four, comparator_out_three,
                     comparator_out_two, comparator_out_one};
  // input-only pins skip this mask: they carry no analog flag here
  assign io_digital = io_sync_reg & ~analog_enable;

  always @* begin
    periph_in_next = {`NUM_PERIPH_IN{1'b0}};
    for (in_idx = 0; in_idx < `NUM_PERIPH_IN; in_idx = in_idx + 1)
      periph_in_next[in_idx] = route_in(input_map_selector_reg[in_idx], io_digital, ionly_sync_reg, virt_src);
  end

  // ----------------------------------------------------------------
  // output routing
  // ----------------------------------------------------------------
  reg [`NUM_RP_PINS-1:0] pin_out_next;
  reg [`NUM_RP_PINS-1:0] pin_oe_next;
  reg mapped;
  reg level;

  always @* begin
    pin_out_next = {`NUM_RP_PINS{1'b0}};
    pin_oe_next = {`NUM_RP_PINS{1'b0}};
    mapped = 1'b0;
    level = 1'b0;
    for (out_idx = 0; out_idx < `NUM_RP_PINS; out_idx = out_idx + 1) begin
      mapped = 1'b1;
      case (output_map_selector_reg[out_idx])
        `OUT_UART1_TX: level = uart_one_transmit;
        `OUT_UART2_TX: level = uart_two_transmit;
        `OUT_SPI_DO: level = spi_b_data_out;
        `OUT_SPI_CK: level = spi_b_clock_out;
        `OUT_SPI_SS: level = spi_b_select_out;
        `OUT_CAN_TX: level = can_transmit;
        `OUT_OC1: level = compare_out_one;
        `OUT_OC2: level = compare_out_two;
        `OUT_OC3: level = compare_out_three;
        `OUT_OC4: level = compare_out_four;
        `OUT_CMP1: level = comparator_out_one;
        `OUT_CMP2: level = comparator_out_two;
        `OUT_CMP3: level = comparator_out_three;
        `OUT_CMP4: level = comparator_out_four;
        `OUT_SYNC: level = pwm_sync_out;
        `OUT_QCMP: level = encoder_count_compare_out;
        `OUT_REFCLK: level = reference_clock_out;
        default: begin
          mapped = 1'b0;
          level = 1'b0;
        end
      endcase
      // analog use of the pin keeps the remapped driver off
      if (mapped && !analog_enable[out_idx]) begin
        pin_out_next[out_idx] = level;
        pin_oe_next[out_idx] = 1'b1;
      end else begin
        pin_out_next[out_idx] = port_data_out[out_idx];
        pin_oe_next[out_idx] = port_data_oe[out_idx];
      end
    end
  end

  // registered so a selector change never shows decode glitches on the pads
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_in <= {`NUM_PERIPH_IN{1'b0}};
      remappable_io_pin_out <= {`NUM_RP_PINS{1'b0}};
      remappable_io_pin_oe <= {`NUM_RP_PINS{1'b0}};
    end else begin
      periph_in <= periph_in_next;
      remappable_io_pin_out <= pin_out_next;
      remappable_io_pin_oe <= pin_oe_next;
    end
  end

endmodule // remappable_pin_select_mux

// File: sim/periph_model.sv
// Purpose: stand-in for the on-chip peripherals and the pad levels
// Assumes: sources are synchronous to sys_clk; pads are resynchronised by the mux
// Notes: sources take the bench pattern one edge later, like registered peripherals
`timescale 1ns/10ps
module periph_model (
  // clock
  input wire sys_clk,
  // requested levels
  input wire [55:0] pat,
  // outputs, virtual sources, full pins, input-only pins from bit 0 up
  output reg [55:0] drv
);
  // ------------------------------------------------------------
  // sources
  // ------------------------------------------------------------
  // filtered index and home move freely, as if the encoder were on and fed from a pin
  always @(posedge sys_clk) begin
    drv <= pat;
  end
endmodule // periph_model

// File: sim/pin_select_checker_asserts.sv
// Purpose: port-level checks of the pin select mux
// Assumes: fault one input selector at 0x08, pin 0 output selector at 0x20
// Notes: only those two selectors are shadowed, to keep the helper logic small
`timescale 1ns/10ps
`include "pin_select_defines.vh"
module pin_select_checker (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // register port
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [`DATA_W-1:0] reg_rdata,
  // pins, sources and routed inputs
  input wire [`NUM_RP_PINS-1:0] port_data_out,
  input wire [`NUM_RP_PINS-1:0] analog_enable,
  input wire [`NUM_RP_PINS-1:0] remappable_io_pin_out,
  input wire [`NUM_RP_PINS-1:0] remappable_io_pin_oe,
  input wire comparator_out_one,
  input wire uart_one_transmit,
  input wire [`NUM_PERIPH_IN-1:0] periph_in
);
  reg [6:0] in_sel_reg;
  reg [5:0] out_sel_reg;
  reg up_reg;
  // ------------------------------------------------------------
  // shadows; up_reg masks the first edge, whose outputs still hold reset values
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_sel_reg <= 7'h00;
      out_sel_reg <= 6'h00;
      up_reg <= 1'b0;
    end else begin
      up_reg <= 1'b1;
      if (reg_wr && reg_addr == 6'h08)
        in_sel_reg <= reg_wdata[6:0];
      if (reg_wr && reg_addr == 6'h20)
        out_sel_reg <= reg_wdata[5:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_default_out;
    up_reg && (out_sel_reg == `OUT_DEFAULT || out_sel_reg == 6'h02) |=> remappable_io_pin_out[0] == $past(port_data_out[0]);
  endproperty
  a_default_out: assert property (p_default_out) else $error("pin 0 left its port value");
  property p_analog_out;
    up_reg && analog_enable[0] |=> remappable_io_pin_out[0] == $past(port_data_out[0]);
  endproperty
  a_analog_out: assert property (p_analog_out) else $error("analog pin taken by remap");
  property p_uart_out;
    up_reg && out_sel_reg == `OUT_UART1_TX && !analog_enable[0] |=> remappable_io_pin_oe[0] && remappable_io_pin_out[0] == $past(uart_one_transmit);
  endproperty
  a_uart_out: assert property (p_uart_out) else $error("pin 0 not fed by uart one");
  property p_cmp_out;
    up_reg && out_sel_reg == `OUT_CMP1 && !analog_enable[0] |=> remappable_io_pin_oe[0] && remappable_io_pin_out[0] == $past(comparator_out_one);
  endproperty
  a_cmp_out: assert property (p_cmp_out) else $error("pin 0 not fed by comparator one");
  property p_fault_cmp;
    up_reg && in_sel_reg == `IN_CMP1 |=> periph_in[8] == $past(comparator_out_one);
  endproperty
  a_fault_cmp: assert property (p_fault_cmp) else $error("fault one not fed by comparator");
  property p_ground;
    (up_reg && in_sel_reg == `IN_GROUND) [*2] |=> !periph_in[8];
  endproperty
  a_ground: assert property (p_ground) else $error("grounded input reads high");
  property p_invalid;
    up_reg && (in_sel_reg == 7'h05 || in_sel_reg == 7'h7f) |=> !periph_in[8];
  endproperty
  a_invalid: assert property (p_invalid) else $error("empty code reads high");
  property p_readback;
    reg_rd && reg_addr == 6'h08 |=> reg_rdata == {9'h000, $past(in_sel_reg)};
  endproperty
  a_readback: assert property (p_readback) else $error("selector readback wrong");
  c_uart: cover property (up_reg && out_sel_reg == `OUT_UART1_TX && uart_one_transmit);
  c_fault: cover property (in_sel_reg == `IN_CMP1 && comparator_out_one);
  c_analog: cover property (analog_enable[0] && out_sel_reg != `OUT_DEFAULT);
endmodule // pin_select_checker

bind remappable_pin_select_mux pin_select_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_data_out(port_data_out),
  .analog_enable(analog_enable), .remappable_io_pin_out(remappable_io_pin_out),
  .remappable_io_pin_oe(remappable_io_pin_oe), .comparator_out_one(comparator_out_one),
  .uart_one_transmit(uart_one_transmit), .periph_in(periph_in));

// File: sim/testbench.sv
// Purpose: self-checking bench for the pin select mux
// Assumes: fixed routing latencies of the hand-over, five edges cover the longest
// Notes: code tables are packed bytes, entry 0 in the low byte, ff marks no source
`timescale 1ns/10ps
`include "pin_select_defines.vh"
module testbench;
  localparam [119:0] in_code = 120'h76_00_7f_05_79_61_14_09_08_07_06_04_03_02_01;
  localparam [119:0] in_bit = 120'hff_ff_ff_ff_37_23_15_14_13_12_11_10_0f_0e_0d;
  localparam [159:0] out_code = 160'h00_3f_02_32_1a_19_18_31_2f_2d_13_12_11_10_0e_0a_09_08_03_01;
  localparam [159:0] out_bit = 160'hff_ff_ff_10_0f_0e_0d_0c_0b_0a_09_08_07_06_05_04_03_02_01_00;
  reg sys_clk, rst_n, reg_wr, reg_rd;
  reg [5:0] reg_addr;
  reg [15:0] reg_wdata;
  reg [14:0] port_data_out, port_data_oe, analog_enable;
  reg [55:0] pat;
  reg [7:0] c, b;
  wire [15:0] reg_rdata;
  wire [14:0] pin_out, pin_oe;
  wire [23:0] periph_in;
  wire [55:0] drv;
  integer n_mismatch, checks, j;
  // ------------------------------------------------------------
  // harness
  // ------------------------------------------------------------
  periph_model model (.sys_clk(sys_clk), .pat(pat), .drv(drv));
  remappable_pin_select_mux dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .remappable_io_pin_in(drv[35:21]),
    .remappable_input_only_pin(drv[55:36]), .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .analog_enable(analog_enable), .remappable_io_pin_out(pin_out), .remappable_io_pin_oe(pin_oe),
    .comparator_out_one(drv[13]), .comparator_out_two(drv[14]), .comparator_out_three(drv[15]),
    .comparator_out_four(drv[16]), .trigger_gen_out_30(drv[17]), .trigger_gen_out_31(drv[18]),
    .filtered_encoder_index(drv[19]), .filtered_encoder_home(drv[20]), .uart_one_transmit(drv[0]),
    .uart_two_transmit(drv[1]), .spi_b_data_out(drv[2]), .spi_b_clock_out(drv[3]), .spi_b_select_out(drv[4]),
    .can_transmit(drv[5]), .compare_out_one(drv[6]), .compare_out_two(drv[7]), .compare_out_three(drv[8]),
    .compare_out_four(drv[9]), .pwm_sync_out(drv[10]), .encoder_count_compare_out(drv[11]),
    .reference_clock_out(drv[12]), .periph_in(periph_in));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [5:0] a, input [15:0] d);
    begin
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [5:0] a, input [15:0] exp);
    begin
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk(reg_rdata, exp);
    end
  endtask
  task drive(input [55:0] p);
    begin
      @(posedge sys_clk);
      pat <= p;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_regs;
    begin
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(pin_out, port_data_out);
      chk(pin_oe, port_data_oe);
      chk(periph_in, 24'h000000);
      for (j = 0; j < 24; j = j + 1) rd(j[5:0], 16'h0000);
      for (j = 0; j < 15; j = j + 1) rd(6'h20 + j[5:0], 16'h0000);
      wr(6'h08, 16'hff81);
      rd(6'h08, 16'h0001);
      wr(6'h20, 16'hffff);
      rd(6'h20, 16'h003f);
      wr(6'h18, 16'h00ff);
      rd(6'h18, 16'h0000);
      rd(6'h3f, 16'h0000);
    end
  endtask
  task t_inputs;
    for (j = 0; j < 15; j = j + 1) begin
      c = in_code[j*8 +: 8];
      b = in_bit[j*8 +: 8];
      wr(6'h08, {8'h00, c});
      if (b != 8'hff) begin
        drive(56'h1 << b);
        chk(periph_in[8], 1'b1);
        drive(~(56'h1 << b));
        chk(periph_in[8], 1'b0);
      end else begin
        drive(~56'h0);
        chk(periph_in[8], 1'b0);
      end
    end
  endtask
  task t_outputs;
    for (j = 0; j < 20; j = j + 1) begin
      c = out_code[j*8 +: 8];
      b = out_bit[j*8 +: 8];
      wr(6'h20, {8'h00, c});
      if (b != 8'hff) begin
        drive(56'h1 << b);
        chk({pin_oe[0], pin_out[0]}, 2'b11);
        drive(~(56'h1 << b));
        chk({pin_oe[0], pin_out[0]}, 2'b10);
        chk(pin_out[14:1], port_data_out[14:1]);
      end else begin
        drive(~56'h0);
        chk({pin_oe[0], pin_out[0]}, {port_data_oe[0], port_data_out[0]});
      end
    end
  endtask
  task t_analog;
    begin
      @(posedge sys_clk);
      analog_enable <= 15'h0001;
      wr(6'h08, 16'h0014);
      wr(6'h20, 16'h0001);
      drive(~56'h0);
      chk(periph_in[8], 1'b0);
      chk(pin_out[0], port_data_out[0]);
      @(posedge sys_clk);
      analog_enable <= 15'h0000;
      drive(~56'h0);
      chk({pin_oe[0], pin_out[0]}, 2'b11);
      chk(periph_in[8], 1'b1);
    end
  endtask
  task t_many;
    begin
      for (j = 0; j < 24; j = j + 1) wr(j[5:0], 16'h0001);
      for (j = 0; j < 15; j = j + 1) wr(6'h20 + j[5:0], 16'h0010);
      drive(56'h2040);
      chk(periph_in, 24'hffffff);
      chk({pin_oe, pin_out}, 30'h3fffffff);
      drive(56'h0);
      chk(periph_in, 24'h000000);
      chk(pin_out, 15'h0000);
    end
  endtask
  task final_report;
    begin
      $display("mismatches %0d, checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (50000) @(posedge sys_clk);
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, pat} = 0;
    port_data_out = 15'h2a5a;
    port_data_oe = 15'h1235;
    analog_enable = 15'h0000;
    n_mismatch = 0;
    checks = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs;
    t_inputs;
    t_outputs;
    t_analog;
    t_many;
    final_report;
  end
endmodule // testbench
